/* common/ocsw_regs.svh */
// Purpose: Constants for the octal switch channel control block.
// Assumes: A 10 MHz core clock.
// Notes:   Register addresses are the 3-bit select codes on the configuration port.
`ifndef OCSW_REGS_SVH
`define OCSW_REGS_SVH

// ==========================================================
// Register select codes
`define OCSW_ADDR_MAP 3'h1
`define OCSW_ADDR_BOL 3'h2
`define OCSW_ADDR_OVL 3'h3
`define OCSW_ADDR_OVT 3'h4
`define OCSW_ADDR_SLE 3'h5
`define OCSW_ADDR_STA 3'h6
`define OCSW_ADDR_CTL 3'h7

// ==========================================================
// Reset values
`define OCSW_RST_MAP 8'h08
`define OCSW_RST_BOL 8'h00
`define OCSW_RST_OVL 8'h00
`define OCSW_RST_OVT 8'h00
`define OCSW_RST_SLE 8'h00
`define OCSW_RST_CTL 8'h00

// ==========================================================
// Field positions
`define OCSW_MAPPED_IN_BIT 3
`define OCSW_DEDICATED_INS 3

// ==========================================================
// Timing
`define OCSW_CLK_MHZ 10
`define OCSW_FAULT_FILTER_US 200
`define OCSW_OVL_OFF_DELAY_US 50
`define OCSW_SLEW_FAST_US 15
`define OCSW_SLEW_SLOW_US 60
`define OCSW_FAULT_FILTER_CYC (`OCSW_FAULT_FILTER_US * `OCSW_CLK_MHZ)
`define OCSW_OVL_OFF_DELAY_CYC (`OCSW_OVL_OFF_DELAY_US * `OCSW_CLK_MHZ)

`endif

/* common/ocsw_pkg.sv */
// Purpose: Types shared by the octal switch channel control block.
// Assumes: Eight channels.
// Notes:   Constants live in ocsw_regs.svh.
package ocsw_pkg;
   typedef logic [7:0] ocsw_byte_t;
   typedef logic [2:0] ocsw_addr_t;
endpackage

/* verilog/ocsw_sync.sv */
// Purpose: Two-flop synchroniser bank for asynchronous inputs.
// Assumes: Inputs are quasi-static compared with the clock.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module ocsw_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule // ocsw_sync

/* verilog/ocsw_channel_ctrl.sv */
// Purpose: Per-channel on/off control and protection for an eight-channel low-side switch.
// Assumes: Pins and analog sensor flags are asynchronous; configuration writes come from
//          serial-interface logic on ref_clk.
// Notes:   Serial framing, diagnosis encoding and the fault pin live elsewhere.
//
// Operation
// - Each channel is driven by its serial bit alone or combined with parallel input.
// - Serial and parallel combine by OR or by AND, as selected.
// - The AND/OR choice is held separately for each of the eight channels.
// - Serial bits are active high; parallel polarity follows the polarity select pin.
// - Polarity select high makes parallel inputs active high; low makes them active low.
// - The mappable fourth input controls any chosen subset of channels via the map.
// - After reset the map routes the mappable input to the fourth channel (map bit 3) only.
// - Each channel has its own slow or fast switching-speed select.
// - Overtemperature trip turns the channel off at once and records a fault.
// - Overtemperature reaction is per channel: auto-restart or latching.
// - Auto-restart turns the channel back on when the sensor clears and input is on.
// - Latching keeps the channel off until a new rising edge of its input.
// - Overtemperature is evaluated only while the channel is on.
// - Sleep pin low forces outputs off and disables diagnosis.
// - Entering sleep clears diagnosis and the serial on/off register.
// - After sleep only channels driven on by parallel inputs turn on.
// - Overload reaction is limit only, or limit followed by shutdown.
// - Limit only: limiting longer than the filter time records an overload fault.
// - Limit only: overload never switches the channel off.
// - Limit plus shutdown: limiting past the off delay latches the channel off.
// - The overload latch clears on a rising edge of the controlling input or on entering sleep.
`timescale 1ns/1ps
`include "ocsw_regs.svh"
module ocsw_channel_ctrl import ocsw_pkg::*; #(
   parameter int NCH = 8,
   parameter int CNT_W = 12,
   parameter int FILTER_CYC = `OCSW_FAULT_FILTER_CYC,
   parameter int OFF_CYC = `OCSW_OVL_OFF_DELAY_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Device pins
   input wire logic sleep_n,
   input wire logic parallel_polarity_select,
   input wire logic [3:0] par_in,
   // Analog sensor flags per channel
   input wire logic [NCH-1:0] ovt_sense,
   input wire logic [NCH-1:0] ilim_sense,
   // Configuration port
   input wire logic cfg_wr,
   input wire logic [2:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_defaults,
   input wire logic [2:0] rd_addr,
   output logic [7:0] rd_data,
   // Diagnosis
   input wire logic diag_clr,
   output logic [NCH-1:0] ovt_fault,
   output logic [NCH-1:0] ovl_fault,
   output logic diag_enable,
   // Power stage control
   output logic [NCH-1:0] out_on,
   output logic [NCH-1:0] slew_slow
);
   localparam int NSYNC = 2 * NCH + 6;
   localparam logic [CNT_W-1:0] FILTER_LIM = CNT_W'(FILTER_CYC);
   localparam logic [CNT_W-1:0] OFF_LIM = CNT_W'(OFF_CYC);
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   // ==========================================================
   // Reset release and input synchronisation
   logic rst_meta_q;
   logic rst_n_s;
   logic [NSYNC-1:0] sync_in;
   logic [NSYNC-1:0] sync_out;
   logic sleep_s;
   logic pol_s;
   logic [3:0] par_s;
   logic [NCH-1:0] ovt_s;
   logic [NCH-1:0] ilim_s;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_s <= rst_meta_q;
      end
   end

   // The two pulled-up pins enter inverted, so that a cleared synchroniser reads them as high.
   assign sync_in = {ilim_sense, ovt_sense, par_in, ~parallel_polarity_select, ~sleep_n};
   ocsw_sync #(
      .W(NSYNC)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n_s),
      .din(sync_in),
      .dout(sync_out)
   );
   assign sleep_s = sync_out[0];
   assign pol_s = ~sync_out[1];
   assign par_s = sync_out[5:2];
   assign ovt_s = sync_out[NCH+5:6];
   assign ilim_s = sync_out[2*NCH+5:NCH+6];

   // ==========================================================
   // Configuration registers
   ocsw_byte_t map_q, map_d;
   ocsw_byte_t bol_q, bol_d;
   ocsw_byte_t ovl_q, ovl_d;
   ocsw_byte_t ovt_q, ovt_d;
   ocsw_byte_t sle_q, sle_d;
   ocsw_byte_t ctl_q, ctl_d;
   ocsw_byte_t rd_q, rd_d;
   logic [NCH-1:0] out_q;

   always_comb begin
      map_d = map_q;
      bol_d = bol_q;
      ovl_d = ovl_q;
      ovt_d = ovt_q;
      sle_d = sle_q;
      ctl_d = ctl_q;
      if (cfg_defaults) begin
         map_d = `OCSW_RST_MAP;
         bol_d = `OCSW_RST_BOL;
         ovl_d = `OCSW_RST_OVL;
         ovt_d = `OCSW_RST_OVT;
         sle_d = `OCSW_RST_SLE;
         ctl_d = `OCSW_RST_CTL;
      end else if (cfg_wr) begin
         case (cfg_addr)
            `OCSW_ADDR_MAP: map_d = cfg_wdata;
            `OCSW_ADDR_BOL: bol_d = cfg_wdata;
            `OCSW_ADDR_OVL: ovl_d = cfg_wdata;
            `OCSW_ADDR_OVT: ovt_d = cfg_wdata;
            `OCSW_ADDR_SLE: sle_d = cfg_wdata;
            `OCSW_ADDR_CTL: ctl_d = cfg_wdata;
            default: ;
         endcase
      end
      if (sleep_s) begin
         ctl_d = `OCSW_RST_CTL;
      end
      case (rd_addr)
         `OCSW_ADDR_MAP: rd_d = map_q;
         `OCSW_ADDR_BOL: rd_d = bol_q;
         `OCSW_ADDR_OVL: rd_d = ovl_q;
         `OCSW_ADDR_OVT: rd_d = ovt_q;
         `OCSW_ADDR_SLE: rd_d = sle_q;
         `OCSW_ADDR_STA: rd_d = ocsw_byte_t'(out_q);
         `OCSW_ADDR_CTL: rd_d = ctl_q;
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         map_q <= `OCSW_RST_MAP;
         bol_q <= `OCSW_RST_BOL;
         ovl_q <= `OCSW_RST_OVL;
         ovt_q <= `OCSW_RST_OVT;
         sle_q <= `OCSW_RST_SLE;
         ctl_q <= `OCSW_RST_CTL;
         rd_q <= 8'h00;
      end else begin
         map_q <= map_d;
         bol_q <= bol_d;
         ovl_q <= ovl_d;
         ovt_q <= ovt_d;
         sle_q <= sle_d;
         ctl_q <= ctl_d;
         rd_q <= rd_d;
      end
   end

   assign rd_data = rd_q;

   // ==========================================================
   // Parallel input polarity
   logic [3:0] par_act;
   logic mapped_in;

   assign par_act = pol_s ? par_s : ~par_s;
   assign mapped_in = par_act[`OCSW_MAPPED_IN_BIT];

   // ==========================================================
   // Per-channel control and protection
   logic [NCH-1:0] ovt_flt_q;
   logic [NCH-1:0] ovl_flt_q;
   logic [NCH-1:0] slew_q;

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         logic par_bit;
         logic use_par;
         logic eff;
         logic rise;
         logic eprev_q, eprev_d;
         logic ovth_q, ovth_d;
         logic ovlh_q, ovlh_d;
         logic oflt_q, oflt_d;
         logic lflt_q, lflt_d;
         logic on_q, on_d;
         logic sl_q, sl_d;
         logic [CNT_W-1:0] cnt_q, cnt_d;
         logic lim_hit;

         if (gi < `OCSW_DEDICATED_INS) begin : g_ded
            assign par_bit = map_q[gi] ? mapped_in : par_act[gi];
            assign use_par = 1'b1;
         end else begin : g_map
            assign par_bit = map_q[gi] & mapped_in;
            assign use_par = map_q[gi];
         end

         assign eff = !use_par ? ctl_q[gi] : (bol_q[gi] ? (ctl_q[gi] & par_bit) : (ctl_q[gi] | par_bit));
         assign rise = eff & ~eprev_q;
         assign lim_hit = ovl_q[gi] ? (cnt_q == OFF_LIM) : (cnt_q == FILTER_LIM);

         always_comb begin
            eprev_d = sleep_s ? 1'b0 : eff;
            // Overload limiting time, counted only while on and limiting.
            if (sleep_s || !on_q || !ilim_s[gi]) begin
               cnt_d = '0;
            end else if (cnt_q != CNT_MAX) begin
               cnt_d = cnt_q + 1'b1;
            end else begin
               cnt_d = cnt_q;
            end
            if (sleep_s) begin
               ovth_d = 1'b0;
            end else if (on_q && ovt_s[gi]) begin
               ovth_d = 1'b1;
            end else if (ovt_q[gi]) begin
               ovth_d = ovth_q & ~rise;
            end else begin
               ovth_d = ovth_q & ovt_s[gi];
            end
            if (sleep_s) begin
               ovlh_d = 1'b0;
            end else if (ovl_q[gi] && on_q && ilim_s[gi] && lim_hit) begin
               ovlh_d = 1'b1;
            end else begin
               ovlh_d = ovlh_q & ~rise;
            end
            on_d = ~sleep_s & eff & ~ovth_d & ~ovlh_d;
            if (sleep_s) begin
               oflt_d = 1'b0;
            end else if (on_q && ovt_s[gi]) begin
               oflt_d = 1'b1;
            end else begin
               oflt_d = oflt_q & ~diag_clr;
            end
            if (sleep_s) begin
               lflt_d = 1'b0;
            end else if (on_q && ilim_s[gi] && lim_hit) begin
               lflt_d = 1'b1;
            end else begin
               lflt_d = lflt_q & ~diag_clr;
            end
            sl_d = sle_q[gi];
         end

         always_ff @(posedge ref_clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
               eprev_q <= 1'b0;
               ovth_q <= 1'b0;
               ovlh_q <= 1'b0;
               oflt_q <= 1'b0;
               lflt_q <= 1'b0;
               on_q <= 1'b0;
               sl_q <= 1'b0;
               cnt_q <= '0;
            end else begin
               eprev_q <= eprev_d;
               ovth_q <= ovth_d;
               ovlh_q <= ovlh_d;
               oflt_q <= oflt_d;
               lflt_q <= lflt_d;
               on_q <= on_d;
               sl_q <= sl_d;
               cnt_q <= cnt_d;
            end
         end

         assign out_q[gi] = on_q;
         assign ovt_flt_q[gi] = oflt_q;
         assign ovl_flt_q[gi] = lflt_q;
         assign slew_q[gi] = sl_q;
      end
   endgenerate

   // ==========================================================
   // Outputs
   logic diag_en_q;

   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         diag_en_q <= 1'b0;
      end else begin
         diag_en_q <= ~sleep_s;
      end
   end

   assign out_on = out_q;
   assign ovt_fault = ovt_flt_q;
   assign ovl_fault = ovl_flt_q;
   assign slew_slow = slew_q;
   assign diag_enable = diag_en_q;
endmodule // ocsw_channel_ctrl

/* testbench/ocsw_host_model.sv */
// Purpose: Host model driving the pins and the configuration port.
// Assumes: Everything changes by non-blocking assignment at the rising edge.
// Notes: The bench calls the tasks by hierarchical name.
`timescale 1ns/1ps
module ocsw_host_model #(
   parameter int DIAG_GAP = 2000
) (
   // Clock
   input wire logic ref_clk,
   // Pins
   output logic sleep_n,
   output logic parallel_polarity_select,
   output logic [3:0] par_in,
   // Configuration port
   output logic cfg_wr,
   output logic [2:0] cfg_addr,
   output logic [7:0] cfg_wdata,
   output logic cfg_defaults,
   output logic [2:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic diag_clr
);
   initial begin
      {sleep_n, parallel_polarity_select, cfg_wr, cfg_defaults, diag_clr} = 5'h18;
      par_in = 4'h0;
      cfg_addr = 3'h0;
      cfg_wdata = 8'h00;
      rd_addr = 3'h0;
   end
   task automatic pins(input logic s, input logic p, input logic [3:0] i);
      @(posedge ref_clk);
      sleep_n <= s;
      parallel_polarity_select <= p;
      par_in <= i;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic strobe(input logic dflt);
      @(posedge ref_clk);
      cfg_defaults <= dflt;
      diag_clr <= ~dflt;
      @(posedge ref_clk);
      cfg_defaults <= 1'b0;
      diag_clr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      rd_addr <= a;
      repeat (DIAG_GAP) @(posedge ref_clk);
      #1;
      d = rd_data;
   endtask
endmodule // ocsw_host_model

/* testbench/ocsw_channel_ctrl_chk.sv */
// Purpose: Concurrent checks on the channel control ports.
// Assumes: One clock domain.
// Notes: Bound into every channel control instance.
`timescale 1ns/1ps
module ocsw_channel_ctrl_chk #(
   parameter int OFF_CYC = 500
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Inputs
   input wire logic sleep_n,
   input wire logic [7:0] ovt_sense,
   input wire logic [7:0] ilim_sense,
   input wire logic cfg_wr,
   input wire logic [2:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic cfg_defaults,
   input wire logic [2:0] rd_addr,
   // Outputs
   input wire logic [7:0] rd_data,
   input wire logic [7:0] ovt_fault,
   input wire logic [7:0] ovl_fault,
   input wire logic diag_enable,
   input wire logic [7:0] out_on,
   input wire logic [7:0] slew_slow
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_asleep;
      !sleep_n [*5];
   endsequence
   sequence s_dflt;
      cfg_defaults ##1 (rd_addr == 3'h1 && !cfg_wr) [*2];
   endsequence
   property p_sleep_off;
      s_asleep |-> out_on == 8'h00 && !diag_enable;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("output on in sleep");
   property p_sleep_clr;
      s_asleep |-> ovt_fault == 8'h00 && ovl_fault == 8'h00;
   endproperty
   a_sleep_clr: assert property (p_sleep_clr) else $error("fault kept in sleep");
   property p_diag_on;
      sleep_n [*8] |-> diag_enable;
   endproperty
   a_diag_on: assert property (p_diag_on) else $error("diagnosis off while awake");
   property p_ovt_trip;
      (out_on[0] && ovt_sense[0]) [*3] |=> !out_on[0];
   endproperty
   a_ovt_trip: assert property (p_ovt_trip) else $error("no overtemperature trip");
   property p_ovt_fault;
      $rose(ovt_fault[0]) |-> !out_on[0] && $past(out_on[0]);
   endproperty
   a_ovt_fault: assert property (p_ovt_fault) else $error("bad overtemperature fault");
   property p_ovl_wait;
      $rose(ovl_fault[0]) |-> $past(ilim_sense[0], OFF_CYC);
   endproperty
   a_ovl_wait: assert property (p_ovl_wait) else $error("early overload fault");
   property p_slew;
      (cfg_wr && cfg_addr == 3'h5 && !cfg_defaults) |-> ##2 slew_slow == $past(cfg_wdata, 2);
   endproperty
   a_slew: assert property (p_slew) else $error("speed select not applied");
   property p_map_dflt;
      s_dflt |=> rd_data == 8'h08;
   endproperty
   a_map_dflt: assert property (p_map_dflt) else $error("map default wrong");
endmodule // ocsw_channel_ctrl_chk
bind ocsw_channel_ctrl ocsw_channel_ctrl_chk #(.OFF_CYC(OFF_CYC)) u_ocsw_channel_ctrl_chk (
   .ref_clk, .reset_n, .sleep_n, .ovt_sense, .ilim_sense, .cfg_wr, .cfg_addr, .cfg_wdata,
   .cfg_defaults, .rd_addr, .rd_data, .ovt_fault, .ovl_fault, .diag_enable, .out_on, .slew_slow
);

/* testbench/test_octal_switch_channel_control.sv */
// Purpose: Self-checking bench for the channel control block.
// Assumes: Shortened fault counts of 20 and 8 cycles.
// Notes: Sensor flags and reset_n are driven here, the host model drives the rest.
`timescale 1ns/1ps
module test_octal_switch_channel_control import ocsw_pkg::*; ;
   localparam int FILT_C = 20;
   localparam int OFF_C = 8;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] ovt_sense = 8'h00;
   logic [7:0] ilim_sense = 8'h00;
   logic sleep_n, parallel_polarity_select, cfg_wr, cfg_defaults, diag_clr, diag_enable;
   logic [3:0] par_in;
   logic [2:0] cfg_addr, rd_addr;
   logic [7:0] cfg_wdata, rd_data, ovt_fault, ovl_fault, out_on, slew_slow;
   int err_total = 0;
   int cmp_count = 0;
   always #50 ref_clk = ~ref_clk;
   ocsw_host_model u_ocsw_host_model (
      .ref_clk, .sleep_n, .parallel_polarity_select, .par_in, .cfg_wr, .cfg_addr,
      .cfg_wdata, .cfg_defaults, .rd_addr, .rd_data, .diag_clr
   );
   ocsw_channel_ctrl #(.FILTER_CYC(FILT_C), .OFF_CYC(OFF_C)) u_ocsw_channel_ctrl (
      .ref_clk, .reset_n, .sleep_n, .parallel_polarity_select, .par_in, .ovt_sense,
      .ilim_sense, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_defaults, .rd_addr, .rd_data,
      .diag_clr, .ovt_fault, .ovl_fault, .diag_enable, .out_on, .slew_slow
   );
   // ==========================================================
   // Helpers
   task automatic chk(input ocsw_byte_t exp, input ocsw_byte_t got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input ocsw_byte_t d);
      u_ocsw_host_model.wr(a, d);
      #1;
   endtask
   task automatic sense(input ocsw_byte_t t, input ocsw_byte_t l);
      @(posedge ref_clk);
      ovt_sense <= t;
      ilim_sense <= l;
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset_values();
      ocsw_byte_t d;
      for (int i = 0; i < 8; i++) begin
         u_ocsw_host_model.rd(i[2:0], d);
         chk((i == 1) ? 8'h08 : 8'h00, d);
      end
      wr(3'h1, 8'h55);
      u_ocsw_host_model.rd(3'h1, d);
      chk(8'h55, d);
      u_ocsw_host_model.strobe(1'b1);
      u_ocsw_host_model.rd(3'h1, d);
      chk(8'h08, d);
   endtask
   task automatic t_combine();
      logic m, p, s;
      for (int i = 0; i < 8; i++) begin
         {m, p, s} = i[2:0];
         wr(3'h2, {6'h00, !m, m});
         wr(3'h7, s ? 8'h13 : 8'h00);
         u_ocsw_host_model.pins(1'b1, 1'b1, {2'h0, p, p});
         tick(6);
         chk({3'h0, s, 2'h0, m ? p | s : p & s, m ? p & s : p | s}, out_on);
      end
   endtask
   task automatic t_polarity_map();
      ocsw_byte_t d;
      wr(3'h2, 8'h00);
      wr(3'h7, 8'h00);
      u_ocsw_host_model.pins(1'b1, 1'b0, 4'hf);
      tick(6);
      chk(8'h00, out_on);
      u_ocsw_host_model.pins(1'b1, 1'b0, 4'h0);
      tick(6);
      chk(8'h0f, out_on);
      wr(3'h1, 8'hf1);
      u_ocsw_host_model.pins(1'b1, 1'b1, 4'h8);
      tick(6);
      chk(8'hf1, out_on);
      u_ocsw_host_model.rd(3'h6, d);
      chk(8'hf1, d);
      wr(3'h1, 8'h08);
      u_ocsw_host_model.pins(1'b1, 1'b1, 4'h0);
      wr(3'h5, 8'ha5);
      chk(8'ha5, slew_slow);
      wr(3'h5, 8'h5a);
      chk(8'h5a, slew_slow);
   endtask
   task automatic t_overtemp();
      wr(3'h7, 8'h01);
      sense(8'h01, 8'h00);
      tick(6);
      chk(8'h00, out_on);
      chk(8'h01, ovt_fault);
      sense(8'h00, 8'h00);
      tick(6);
      chk(8'h01, out_on);
      wr(3'h4, 8'h01);
      sense(8'h01, 8'h00);
      tick(6);
      sense(8'h00, 8'h00);
      tick(6);
      chk(8'h00, out_on);
      wr(3'h7, 8'h00);
      wr(3'h7, 8'h01);
      tick(4);
      chk(8'h01, out_on);
      wr(3'h7, 8'h00);
      sense(8'h01, 8'h00);
      u_ocsw_host_model.strobe(1'b0);
      tick(6);
      chk(8'h00, ovt_fault);
      sense(8'h00, 8'h00);
      wr(3'h4, 8'h00);
   endtask
   task automatic t_overload();
      wr(3'h7, 8'h01);
      sense(8'h00, 8'h01);
      tick(OFF_C + 4);
      chk(8'h00, ovl_fault);
      tick(FILT_C);
      chk(8'h01, out_on);
      chk(8'h01, ovl_fault);
      sense(8'h00, 8'h00);
      u_ocsw_host_model.strobe(1'b0);
      wr(3'h3, 8'h01);
      sense(8'h00, 8'h01);
      tick(OFF_C + 6);
      chk(8'h00, out_on);
      chk(8'h01, ovl_fault);
      sense(8'h00, 8'h00);
      tick(6);
      chk(8'h00, out_on);
      wr(3'h7, 8'h00);
      wr(3'h7, 8'h01);
      tick(4);
      chk(8'h01, out_on);
      sense(8'h00, 8'h01);
      tick(OFF_C + 6);
      sense(8'h00, 8'h00);
   endtask
   task automatic t_sleep();
      u_ocsw_host_model.pins(1'b1, 1'b1, 4'h1);
      wr(3'h7, 8'hff);
      tick(6);
      chk(8'hfe, out_on);
      u_ocsw_host_model.pins(1'b0, 1'b1, 4'h1);
      tick(6);
      chk(8'h00, out_on);
      chk(8'h00, {7'h00, diag_enable});
      chk(8'h00, ovl_fault);
      u_ocsw_host_model.pins(1'b1, 1'b1, 4'h1);
      tick(8);
      chk(8'h01, out_on);
      chk(8'h01, {7'h00, diag_enable});
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      #8000000;
      err_total++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      tick(4);
      t_reset_values();
      t_combine();
      t_polarity_map();
      t_overtemp();
      t_overload();
      t_sleep();
      report_and_stop();
   end
endmodule // test_octal_switch_channel_control
